// *** core/sbs_sync.sv ***
// sbs_sync: three-stage synchroniser for one level into clk
// assumes: d comes from another clock domain, rst is synchronous to clk
`timescale 1ns/1ns
module sbs_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);

  logic ff1;
  logic ff2;
  logic ff3;

  // ff1 feeds ff2 only, to keep metastability off the agree check
  always_ff @(posedge clk) begin
    if (rst) begin
      ff1 <= RST_VAL;
      ff2 <= RST_VAL;
      ff3 <= RST_VAL;
    end else begin
      ff1 <= d;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // a change counts only once two settled stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= RST_VAL;
    end else if (ff2 == ff3) begin
      q <= ff3;
    end
  end

endmodule

// *** core/sbs_tap.sv ***
// sbs_tap: serial test access port of the synchronous sram
// assumes: tck is the test clock, period at least four mclk periods;
// io_ring is the pad ring seen in the mclk domain
`timescale 1ns/1ns

module sbs_tap #(
  parameter int BSR_W = 64,
  parameter logic [sbs_pkg::ID_W-1:0] ID_VALUE = sbs_pkg::ID_VALUE_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tck,
  input wire sbs_pkg::sbs_pins_s pins,
  input wire logic [BSR_W-1:0] io_ring,
  output sbs_pkg::sbs_tdo_s tdo_pin,
  output logic sram_out_hiz
);

  // the shift slice below needs two cells or more
  if (BSR_W < 2) begin : g_bsr_w_check
    $error("boundary register needs at least two cells");
  end

  sbs_pkg::sbs_state_e state;
  sbs_pkg::sbs_state_e next_state;
  logic tms_eff;
  logic tdi_eff;
  logic [sbs_pkg::IR_W-1:0] ir;
  logic [sbs_pkg::IR_W-1:0] ir_sr;
  logic [sbs_pkg::ID_W-1:0] id_sr;
  logic [BSR_W-1:0] bsr;
  logic [BSR_W-1:0] snap;
  logic byp;
  logic sel_bsr;
  logic sel_id;
  logic shifting;
  logic sel_lsb;
  logic freeze;
  logic freeze_m;
  logic hiz_req;
  logic hiz_m;
  logic [2:0] tms_hi_cnt;

  // pads carry pull-ups, so a floating pin reads high
  assign tms_eff = pins.tms_driven ? pins.tms : sbs_pkg::PULL_UP_LEVEL;
  assign tdi_eff = pins.tdi_driven ? pins.tdi : sbs_pkg::PULL_UP_LEVEL;

  // unknown codes fall back to bypass so a shared chain keeps its length
  always_comb begin
    sel_bsr = 1'b0;
    sel_id = 1'b0;
    unique case (ir)
      sbs_pkg::INS_EXTEST,
      sbs_pkg::INS_SAMPLE,
      sbs_pkg::INS_SAMPLE_Z: sel_bsr = 1'b1;
      sbs_pkg::INS_IDCODE: sel_id = 1'b1;
      default: ;
    endcase
  end

  assign shifting = (state == sbs_pkg::ST_SHIFT_DR) ||
                    (state == sbs_pkg::ST_SHIFT_IR);

  always_comb begin
    if (state == sbs_pkg::ST_SHIFT_IR) begin
      sel_lsb = ir_sr[0];
    end else if (sel_bsr) begin
      sel_lsb = bsr[0];
    end else if (sel_id) begin
      sel_lsb = id_sr[0];
    end else begin
      sel_lsb = byp;
    end
  end

  always_comb begin
    next_state = sbs_pkg::ST_RESET;
    unique case (state)
      sbs_pkg::ST_RESET:
        next_state = tms_eff ? sbs_pkg::ST_RESET : sbs_pkg::ST_IDLE;
      sbs_pkg::ST_IDLE:
        next_state = tms_eff ? sbs_pkg::ST_SEL_DR : sbs_pkg::ST_IDLE;
      sbs_pkg::ST_SEL_DR:
        next_state = tms_eff ? sbs_pkg::ST_SEL_IR : sbs_pkg::ST_CAP_DR;
      sbs_pkg::ST_CAP_DR:
        next_state = tms_eff ? sbs_pkg::ST_EXIT1_DR : sbs_pkg::ST_SHIFT_DR;
      sbs_pkg::ST_SHIFT_DR:
        next_state = tms_eff ? sbs_pkg::ST_EXIT1_DR : sbs_pkg::ST_SHIFT_DR;
      sbs_pkg::ST_EXIT1_DR:
        next_state = tms_eff ? sbs_pkg::ST_UPD_DR : sbs_pkg::ST_PAUSE_DR;
      sbs_pkg::ST_PAUSE_DR:
        next_state = tms_eff ? sbs_pkg::ST_EXIT2_DR : sbs_pkg::ST_PAUSE_DR;
      sbs_pkg::ST_EXIT2_DR:
        next_state = tms_eff ? sbs_pkg::ST_UPD_DR : sbs_pkg::ST_SHIFT_DR;
      sbs_pkg::ST_UPD_DR:
        next_state = tms_eff ? sbs_pkg::ST_SEL_DR : sbs_pkg::ST_IDLE;
      sbs_pkg::ST_SEL_IR:
        next_state = tms_eff ? sbs_pkg::ST_RESET : sbs_pkg::ST_CAP_IR;
      sbs_pkg::ST_CAP_IR:
        next_state = tms_eff ? sbs_pkg::ST_EXIT1_IR : sbs_pkg::ST_SHIFT_IR;
      sbs_pkg::ST_SHIFT_IR:
        next_state = tms_eff ? sbs_pkg::ST_EXIT1_IR : sbs_pkg::ST_SHIFT_IR;
      sbs_pkg::ST_EXIT1_IR:
        next_state = tms_eff ? sbs_pkg::ST_UPD_IR : sbs_pkg::ST_PAUSE_IR;
      sbs_pkg::ST_PAUSE_IR:
        next_state = tms_eff ? sbs_pkg::ST_EXIT2_IR : sbs_pkg::ST_PAUSE_IR;
      sbs_pkg::ST_EXIT2_IR:
        next_state = tms_eff ? sbs_pkg::ST_UPD_IR : sbs_pkg::ST_SHIFT_IR;
      sbs_pkg::ST_UPD_IR:
        next_state = tms_eff ? sbs_pkg::ST_SEL_DR : sbs_pkg::ST_IDLE;
      default: next_state = sbs_pkg::ST_RESET;
    endcase
  end

  // tck may never run, so power-up reset must not wait for an edge;
  // the reset state idles the port and, by loading the identity code, drops sram_out_hiz
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      state <= sbs_pkg::ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      ir <= sbs_pkg::INS_IDCODE;
    end else if (state == sbs_pkg::ST_RESET) begin
      ir <= sbs_pkg::INS_IDCODE;
    end else if (state == sbs_pkg::ST_UPD_IR) begin
      ir <= ir_sr;
    end
  end

  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      ir_sr <= sbs_pkg::INS_IDCODE;
    end else if (state == sbs_pkg::ST_CAP_IR) begin
      ir_sr <= {sbs_pkg::IR_CAPTURE_HIGH, sbs_pkg::IR_CAPTURE_LOW};
    end else if (state == sbs_pkg::ST_SHIFT_IR) begin
      ir_sr <= {tdi_eff, ir_sr[sbs_pkg::IR_W-1:1]};
    end
  end

  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      byp <= sbs_pkg::BYPASS_CAPTURE;
    end else if (!sel_bsr && !sel_id) begin
      if (state == sbs_pkg::ST_CAP_DR) begin
        byp <= sbs_pkg::BYPASS_CAPTURE;
      end else if (state == sbs_pkg::ST_SHIFT_DR) begin
        byp <= tdi_eff;
      end
    end
  end

  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      id_sr <= ID_VALUE;
    end else if (sel_id) begin
      if (state == sbs_pkg::ST_CAP_DR) begin
        id_sr <= ID_VALUE;
      end else if (state == sbs_pkg::ST_SHIFT_DR) begin
        id_sr <= {tdi_eff, id_sr[sbs_pkg::ID_W-1:1]};
      end
    end
  end

  // snap is held still by freeze, so reading it here is safe
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      bsr <= '0;
    end else if (sel_bsr) begin
      if (state == sbs_pkg::ST_CAP_DR) begin
        bsr <= snap;
      end else if (state == sbs_pkg::ST_SHIFT_DR) begin
        bsr <= {tdi_eff, bsr[BSR_W-1:1]};
      end
    end
  end

  // raised two tck before capture; needs four mclk of margin to settle
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      freeze <= 1'b0;
    end else begin
      freeze <= sel_bsr && ((next_state == sbs_pkg::ST_SEL_DR) ||
                            (next_state == sbs_pkg::ST_CAP_DR));
    end
  end

  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      hiz_req <= 1'b0;
    end else begin
      hiz_req <= (ir == sbs_pkg::INS_EXTEST) ||
                 (ir == sbs_pkg::INS_SAMPLE_Z);
    end
  end

  // falling edge launch gives the far end half a period of hold
  always_ff @(negedge tck or posedge rst) begin
    if (rst) begin
      tdo_pin.tdo <= 1'b0;
      tdo_pin.tdo_oe <= 1'b0;
    end else begin
      tdo_pin.tdo <= sel_lsb;
      tdo_pin.tdo_oe <= shifting;
    end
  end

  sbs_sync #(
    .RST_VAL(1'b0)
  ) u_freeze_sync (
    .clk(mclk),
    .rst(rst),
    .d(freeze),
    .q(freeze_m)
  );

  sbs_sync #(
    .RST_VAL(1'b0)
  ) u_hiz_sync (
    .clk(mclk),
    .rst(rst),
    .d(hiz_req),
    .q(hiz_m)
  );

  // pad snapshot tracks the ring until the port asks it to hold
  always_ff @(posedge mclk) begin
    if (rst) begin
      snap <= '0;
    end else if (!freeze_m) begin
      snap <= io_ring;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sram_out_hiz <= 1'b0;
    end else begin
      sram_out_hiz <= hiz_m;
    end
  end

  // helper: run length of high mode-select samples, saturating
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      tms_hi_cnt <= 3'h0;
    end else if (!tms_eff) begin
      tms_hi_cnt <= 3'h0;
    end else if (tms_hi_cnt < 3'(sbs_pkg::TMS_RESET_COUNT)) begin
      tms_hi_cnt <= tms_hi_cnt + 3'h1;
    end
  end

  AST_FIVE_HIGH_RESETS:
    assert property (@(posedge tck) disable iff (rst)
      tms_hi_cnt == 3'(sbs_pkg::TMS_RESET_COUNT) |-> state == sbs_pkg::ST_RESET)
    else $error("five high mode selects did not reset the port");

  AST_RESET_LOADS_IDCODE:
    assert property (@(posedge tck) disable iff (rst)
      state == sbs_pkg::ST_RESET |=> ir == sbs_pkg::INS_IDCODE && sel_id)
    else $error("reset state did not load the identity instruction");

  AST_CAPTURE_IR_PATTERN:
    assert property (@(posedge tck) disable iff (rst)
      state == sbs_pkg::ST_CAP_IR |=> ir_sr[1:0] == sbs_pkg::IR_CAPTURE_LOW)
    else $error("instruction capture pattern wrong");

  AST_SHIFT_ENTERS_MSB:
    assert property (@(posedge tck) disable iff (rst)
      state == sbs_pkg::ST_SHIFT_IR |=> ir_sr[sbs_pkg::IR_W-1] == $past(tdi_eff))
    else $error("serial bit did not enter the top instruction bit");

  AST_OE_ONLY_SHIFTING:
    assert property (@(posedge tck) disable iff (rst)
      tdo_pin.tdo_oe == shifting)
    else $error("serial output enable outside shifting states");

  AST_TDO_SHOWS_LSB:
    assert property (@(posedge tck) disable iff (rst)
      tdo_pin.tdo_oe |-> tdo_pin.tdo == sel_lsb)
    else $error("serial output not the selected low bit");

  AST_IDLE_FROM_RESET:
    assert property (@(posedge tck) disable iff (rst)
      state == sbs_pkg::ST_RESET && !tms_eff |=> state == sbs_pkg::ST_IDLE)
    else $error("low mode select in reset did not reach idle");

  AST_BYPASS_PULLUP:
    assert property (@(posedge tck) disable iff (rst)
      state == sbs_pkg::ST_CAP_DR && !sel_bsr && !sel_id ##1
      state == sbs_pkg::ST_SHIFT_DR && !pins.tdi_driven |=> byp == 1'b1)
    else $error("bypass did not take the pulled-up input");

  AST_BYPASS_CAPTURE_LOW:
    assert property (@(posedge tck) disable iff (rst)
      state == sbs_pkg::ST_CAP_DR && !sel_bsr && !sel_id |=> byp == 1'b0)
    else $error("bypass capture did not clear the cell");

  AST_ID_CAPTURE:
    assert property (@(posedge tck) disable iff (rst)
      state == sbs_pkg::ST_CAP_DR && sel_id |=> id_sr == ID_VALUE)
    else $error("identity register not loaded on capture");

endmodule

// *** shared/sbs_pkg.sv ***
// sbs_pkg: shared constants, states and carriers of the sram test port
// assumes: included by every file of the scan block, nothing imported
package sbs_pkg;

  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int TMS_RESET_COUNT = 5;

  // instruction codes; all zeros is the external-test code
  localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

  // fixed capture pattern of the instruction shift stage
  localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
  localparam logic IR_CAPTURE_HIGH = 1'h0;
  localparam logic BYPASS_CAPTURE = 1'h0;
  localparam logic PULL_UP_LEVEL = 1'h1;

  // identity value is arbitrary
  localparam logic [ID_W-1:0] ID_VALUE_DEFAULT = 32'h0000_0001;

  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAP_DR     = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPD_DR     = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAP_IR     = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPD_IR     = 16'h8000
  } sbs_state_e;

  // serial pins as seen at the pads; driven low means no external driver
  typedef struct packed {
    logic tms;
    logic tms_driven;
    logic tdi;
    logic tdi_driven;
  } sbs_pins_s;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } sbs_tdo_s;

endpackage

// *** tb/sbs_ctl_model.sv ***
// sbs_ctl_model: serial scan controller facing the sram test port
// assumes: one test clock period per step call, clock low between frames
`timescale 1ns/1ns
module sbs_ctl_model (
  output logic tck,
  output sbs_pkg::sbs_pins_s pins,
  input wire sbs_pkg::sbs_tdo_s tdo_pin
);
  logic drv_tms;
  logic drv_tdi;

  initial begin
    tck = 1'b0;
    pins = 4'hf;
    drv_tms = 1'b1;
    drv_tdi = 1'b1;
  end

  // rise on a 160 ns grid offset 117 ns, unrelated to the system clock
  task automatic step(input logic tms, input logic tdi, output logic tdo,
                      output logic oe, output logic held);
    longint t;
    t = longint'($time % 160);
    #((197 - t) % 160);
    // a released line shows garbage, the pad pull-up must win
    pins.tms = drv_tms ? tms : ~pins.tms;
    pins.tms_driven = drv_tms;
    pins.tdi = drv_tdi ? tdi : ~pins.tdi;
    pins.tdi_driven = drv_tdi;
    #80;
    tdo = tdo_pin.tdo;
    oe = tdo_pin.tdo_oe;
    tck = 1'b1;
    #1;
    held = (tdo_pin.tdo === tdo) && (tdo_pin.tdo_oe === oe);
    #79;
    tck = 1'b0;
  endtask
endmodule

// *** tb/sbs_tap_tb.sv ***
// sbs_tap_tb: self-checking bench of the sram test port
// assumes: controller model drives the serial pins, pad ring held steady
`timescale 1ns/1ns
module sbs_tap_tb;
  localparam int BW = 8;
  localparam logic [BW-1:0] RING = 8'ha5;
  logic mclk;
  logic rst;
  logic tck;
  logic [BW-1:0] io_ring;
  sbs_pkg::sbs_pins_s pins;
  sbs_pkg::sbs_tdo_s tdo_pin;
  logic sram_out_hiz;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  logic t_tdo;
  logic t_oe;
  logic t_held;

  sbs_tap #(.BSR_W(BW)) i_dut (
    .mclk(mclk),
    .rst(rst),
    .tck(tck),
    .pins(pins),
    .io_ring(io_ring),
    .tdo_pin(tdo_pin),
    .sram_out_hiz(sram_out_hiz)
  );

  sbs_ctl_model i_ctl (
    .tck(tck),
    .pins(pins),
    .tdo_pin(tdo_pin)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic tick(input logic tms, input logic tdi);
    i_ctl.step(tms, tdi, t_tdo, t_oe, t_held);
    check("tdo over rise", {31'h0, t_held}, 32'h1);
  endtask

  // from reset or idle, one scan of n bits, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    dout = '0;
    tick(1'b0, 1'b0);
    tick(1'b1, 1'b0);
    if (ir)
      tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
    tick(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i]);
      dout[i] = t_tdo;
      check("tdo enable in shift", {31'h0, t_oe}, 32'h1);
    end
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
    tick(1'b0, 1'b0);
    check("tdo enable idle", {31'h0, t_oe}, 32'h0);
  endtask

  task automatic load_ir(input logic [2:0] code);
    logic [31:0] got;
    scan(1'b1, 3, {29'h0, code}, got);
    check("instruction capture", got, 32'h1);
    repeat (10) @(negedge mclk);
  endtask

  task automatic test_power_up;
    logic [31:0] got;
    check("tdo enable at reset", {31'h0, tdo_pin.tdo_oe}, 32'h0);
    check("hiz at reset", {31'h0, sram_out_hiz}, 32'h0);
    scan(1'b0, 32, 32'h0, got);
    check("identity", got, sbs_pkg::ID_VALUE_DEFAULT);
    $display("test power_up done");
  endtask

  // reserved codes must behave as the one-bit bypass
  task automatic test_bypass;
    logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
    logic [31:0] got;
    foreach (codes[k]) begin
      load_ir(codes[k]);
      check("hiz in bypass", {31'h0, sram_out_hiz}, 32'h0);
      scan(1'b0, 8, 32'hb4, got);
      check("bypass path", got, 32'h68);
    end
    i_ctl.drv_tdi = 1'b0;
    scan(1'b0, 8, 32'h0, got);
    i_ctl.drv_tdi = 1'b1;
    check("floating tdi", got, 32'hfe);
    $display("test bypass done");
  endtask

  task automatic test_boundary;
    logic [2:0] codes [3] = '{3'h0, 3'h2, 3'h4};
    logic hiz [3] = '{1'b1, 1'b1, 1'b0};
    logic [31:0] got;
    foreach (codes[k]) begin
      load_ir(codes[k]);
      check("memory hiz", {31'h0, sram_out_hiz}, {31'h0, hiz[k]});
      scan(1'b0, 16, 32'hc3, got);
      check("boundary path", got, {16'h0, 8'hc3, RING});
    end
    $display("test boundary done");
  endtask

  task automatic test_tms_reset;
    logic [31:0] got;
    load_ir(sbs_pkg::INS_SAMPLE_Z);
    repeat (5) tick(1'b1, 1'b0);
    scan(1'b0, 32, 32'h0, got);
    check("identity after tms reset", got, sbs_pkg::ID_VALUE_DEFAULT);
    repeat (10) @(negedge mclk);
    check("hiz after tms reset", {31'h0, sram_out_hiz}, 32'h0);
    load_ir(sbs_pkg::INS_BYPASS);
    i_ctl.drv_tms = 1'b0;
    repeat (5) tick(1'b0, 1'b0);
    i_ctl.drv_tms = 1'b1;
    scan(1'b0, 32, 32'h0, got);
    check("identity after floating tms", got, sbs_pkg::ID_VALUE_DEFAULT);
    $display("test tms_reset done");
  endtask

  // about 3100 system clocks expected
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      complete_run;
    end
  end

  initial begin
    rst = 1'b1;
    io_ring = RING;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    test_power_up;
    test_bypass;
    test_boundary;
    test_tms_reset;
    complete_run;
  end
endmodule
